// ---- ccp_oc.sv ----
/*
 * Output compare stage with auto-shutdown: time base, compare matching,
 * output waveform, shutdown gating, status/mask interrupt and an
 * Avalon-MM slave with one wait state.
 * Assumes all inputs are synchronous to clk; one clock domain.
 */
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ccp_cfg.svh"

module ccp_oc (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [5:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire ccp_pkg::ccp_sd_src_t sd_src,
    input  wire logic                ext_input,
    output logic                     compare_out,
    output logic                     irq
);

    logic                  wait_q;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic [15:0]           ctl_q;
    ccp_pkg::ccp_sdc_t     sdc_q;
    logic [31:0]           per_q;
    logic [31:0]           cmpa_q;
    logic [31:0]           cmpb_q;
    logic [31:0]           cmpa_buf_q;
    logic [31:0]           cmpb_buf_q;
    logic [31:0]           tb_q;
    logic                  dir_q;
    logic                  out_q;
    logic                  cmp_out_q;
    logic                  sef_q;
    logic [3:0]            stat_q;
    logic [3:0]            mask_q;
    logic                  irq_q;
    logic                  wr;
    logic                  rd;
    logic [31:0]           wmerge;
    ccp_pkg::ccp_mode_t    mode;
    logic                  wide;
    logic                  single;
    logic                  valid;
    logic                  buffered;
    logic [31:0]           tmask;
    logic [31:0]           ca_eff;
    logic [31:0]           cb_eff;
    logic [31:0]           top;
    logic                  wrap;
    logic                  match_a;
    logic                  match_b;
    logic [7:0]            src_vec;
    logic                  sd_req;
    logic                  sef_set;
    logic                  sef_clr;
    logic [3:0]            events;

    function automatic logic [31:0] merge_be(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, request taken when waitrequest is low

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    assign wr     = avs_write && !wait_q;
    assign rd     = avs_read && !wait_q;
    assign wmerge = merge_be(rdata_d, avs_writedata, avs_byteenable);

    always_comb begin
        rdata_d = `CCP_RST_32;
        unique case (avs_address)
            `CCP_OFS_CTL:  rdata_d = {16'h0000, ctl_q};
            `CCP_OFS_SDC:  rdata_d = {16'h0000, sdc_q};
            `CCP_OFS_PER:  rdata_d = per_q;
            `CCP_OFS_CMPA: rdata_d = cmpa_q;
            `CCP_OFS_CMPB: rdata_d = cmpb_q;
            `CCP_OFS_TMR:  rdata_d = tb_q;
            `CCP_OFS_STAT: rdata_d = {28'h000_0000, stat_q};
            `CCP_OFS_MASK: rdata_d = {28'h000_0000, mask_q};
            `CCP_OFS_EVT:  rdata_d = {30'h0000_0000, sd_req, sef_q};
            default:       rdata_d = `CCP_RST_32;
        endcase
    end

    // data sampled when the wait state starts, stands through the answer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= `CCP_RST_32;
        end else if (avs_read && wait_q) begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= `CCP_RST_16;
        end else if (wr && avs_address == `CCP_OFS_CTL) begin
            ctl_q <= wmerge[15:0] & `CCP_CTL_WMASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdc_q <= ccp_pkg::ccp_sdc_t'(`CCP_RST_16);
        end else if (wr && avs_address == `CCP_OFS_SDC) begin
            sdc_q <= ccp_pkg::ccp_sdc_t'(wmerge[15:0] & `CCP_SDC_WMASK);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            per_q  <= `CCP_RST_32;
            cmpa_q <= `CCP_RST_32;
            cmpb_q <= `CCP_RST_32;
        end else if (wr) begin
            if (avs_address == `CCP_OFS_PER) begin
                per_q <= wmerge;
            end
            if (avs_address == `CCP_OFS_CMPA) begin
                cmpa_q <= wmerge;
            end
            if (avs_address == `CCP_OFS_CMPB) begin
                cmpb_q <= wmerge;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= 4'h0;
        end else if (wr && avs_address == `CCP_OFS_MASK) begin
            mask_q <= wmerge[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode; 32-bit width is honoured by single-edge modes only

    assign mode     = ccp_pkg::ccp_mode_t'(ctl_q[3:0]);
    assign wide     = ctl_q[`CCP_CTL_WIDE_BIT];
    assign single   = mode == ccp_pkg::CCP_MODE_HIGH || mode == ccp_pkg::CCP_MODE_LOW
                   || mode == ccp_pkg::CCP_MODE_TOGGLE;
    assign valid    = ctl_q[`CCP_CTL_ON_BIT] && (single || (!wide &&
                      (mode == ccp_pkg::CCP_MODE_DUAL || mode == ccp_pkg::CCP_MODE_PWM
                    || mode == ccp_pkg::CCP_MODE_CENTER || mode == ccp_pkg::CCP_MODE_VFREQ
                    || mode == ccp_pkg::CCP_MODE_EXT)));
    assign tmask    = (wide && single) ? `CCP_MASK_32B : `CCP_MASK_16B;
    assign buffered = mode == ccp_pkg::CCP_MODE_PWM || mode == ccp_pkg::CCP_MODE_CENTER;
    assign ca_eff   = (buffered ? cmpa_buf_q : cmpa_q) & tmask;
    assign cb_eff   = (buffered ? cmpb_buf_q : cmpb_q) & tmask;
    // variable frequency: compare A sets the period itself
    assign top      = (mode == ccp_pkg::CCP_MODE_VFREQ) ? ca_eff : (per_q & tmask);
    assign wrap     = valid && ((mode == ccp_pkg::CCP_MODE_CENTER) ? (dir_q && tb_q == 32'h0)
                                                                    : (tb_q == top));
    assign match_a  = valid && tb_q == ca_eff;
    assign match_b  = valid && tb_q == cb_eff;

    ////////////////////////////////////////////////////////////////////////
    // time base; counts up/down in center mode, otherwise up to top

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tb_q  <= `CCP_RST_32;
            dir_q <= 1'b0;
        end else if (!valid) begin
            tb_q  <= `CCP_RST_32;
            dir_q <= 1'b0;
        end else if (mode == ccp_pkg::CCP_MODE_CENTER) begin
            if (!dir_q) begin
                if (tb_q >= top) begin
                    dir_q <= 1'b1;
                    tb_q  <= (tb_q == 32'h0) ? tb_q : tb_q - 32'h1;
                end else begin
                    tb_q <= tb_q + 32'h1;
                end
            end else if (tb_q == 32'h0) begin
                dir_q <= 1'b0;
                tb_q  <= (top == 32'h0) ? tb_q : 32'h1;
            end else begin
                tb_q <= tb_q - 32'h1;
            end
        end else if (wrap) begin
            tb_q <= `CCP_RST_32;
        end else begin
            tb_q <= (tb_q + 32'h1) & tmask;
        end
    end

    // shadows load only at period start or while stopped so a duty change never glitches
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmpa_buf_q <= `CCP_RST_32;
            cmpb_buf_q <= `CCP_RST_32;
        end else if (wrap || !valid) begin
            cmpa_buf_q <= cmpa_q;
            cmpb_buf_q <= cmpb_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // waveform; compare B wins a tie so equal values give 0% duty

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= 1'b0;
        end else if (!valid) begin
            out_q <= 1'b0;
        end else begin
            unique case (mode)
                ccp_pkg::CCP_MODE_HIGH: begin
                    if (match_a) begin
                        out_q <= 1'b1;
                    end
                end
                ccp_pkg::CCP_MODE_LOW: begin
                    if (match_a) begin
                        out_q <= 1'b0;
                    end
                end
                ccp_pkg::CCP_MODE_TOGGLE, ccp_pkg::CCP_MODE_VFREQ: begin
                    if (match_a) begin
                        out_q <= !out_q;
                    end
                end
                ccp_pkg::CCP_MODE_DUAL, ccp_pkg::CCP_MODE_PWM: begin
                    if (match_b) begin
                        out_q <= 1'b0;
                    end else if (match_a) begin
                        out_q <= 1'b1;
                    end
                end
                ccp_pkg::CCP_MODE_CENTER: begin
                    out_q <= tb_q >= ca_eff && tb_q < cb_eff;
                end
                ccp_pkg::CCP_MODE_EXT: begin
                    out_q <= ext_input;
                end
                default: begin
                    out_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // auto-shutdown

    assign src_vec = {sd_src.fault_input_b, sd_src.fault_input_a, sd_src.logic_cell_out,
                      2'b00, sd_src.comparator_three_out, sd_src.comparator_two_out,
                      sd_src.comparator_one_out};
    assign sd_req  = |(src_vec & sdc_q.shutdown_source_enable)
                  || sdc_q.software_shutdown_force;
    // gate mode waits for a period start; a stopped timer never releases it
    assign sef_set = sd_req && (!sdc_q.shutdown_gate_sync || wrap);
    assign sef_clr = (sdc_q.auto_restart_enable && wrap && !sd_req)
                  || (wr && avs_address == `CCP_OFS_EVT && avs_writedata[0]
                      && avs_byteenable[0]);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sef_q <= 1'b0;
        end else if (sef_set) begin
            sef_q <= 1'b1;
        end else if (sef_clr) begin
            sef_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_out_q <= 1'b0;
        end else begin
            cmp_out_q <= out_q && !sef_q && !sef_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, cleared by reading it; a new event beats the clear

    assign events = {sef_set && !sef_q, wrap, match_b, match_a};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= 4'h0;
        end else if (rd && avs_address == `CCP_OFS_STAT) begin
            // clear only what the answer reported; events after it survive
            stat_q <= (stat_q & ~rdata_q[3:0]) | events;
        end else begin
            stat_q <= stat_q | events;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign compare_out     = cmp_out_q;
    assign irq             = irq_q;

endmodule

// ---- ccp_cfg.svh ----
/*
 * Register offsets, field positions, write masks and reset values of the
 * output compare stage. Assumes byte addresses on a 32-bit Avalon-MM bus.
 */
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

`define CCP_OFS_CTL        6'h00
`define CCP_OFS_SDC        6'h04
`define CCP_OFS_PER        6'h08
`define CCP_OFS_CMPA       6'h0C
`define CCP_OFS_CMPB       6'h10
`define CCP_OFS_TMR        6'h14
`define CCP_OFS_STAT       6'h18
`define CCP_OFS_MASK       6'h1C
`define CCP_OFS_EVT        6'h20

`define CCP_CTL_ON_BIT     15
`define CCP_CTL_WIDE_BIT   5
`define CCP_CTL_WMASK      16'h802F
`define CCP_SDC_WMASK      16'hD0FF
`define CCP_RST_16         16'h0000
`define CCP_RST_32         32'h0000_0000
`define CCP_MASK_16B       32'h0000_FFFF
`define CCP_MASK_32B       32'hFFFF_FFFF

`define CCP_ST_MATCH_A     0
`define CCP_ST_MATCH_B     1
`define CCP_ST_PERIOD      2
`define CCP_ST_SHUTDOWN    3

`endif

// ---- ccp_pkg.sv ----
/*
 * Types of the output compare stage: compare modes, shutdown control
 * layout and the bundle of shutdown source inputs.
 * Assumes ccp_cfg.svh carries the numeric constants.
 */
package ccp_pkg;

    typedef enum logic [3:0] {
        CCP_MODE_HIGH   = 4'h1,
        CCP_MODE_LOW    = 4'h2,
        CCP_MODE_TOGGLE = 4'h3,
        CCP_MODE_DUAL   = 4'h4,
        CCP_MODE_PWM    = 4'h5,
        CCP_MODE_CENTER = 4'h6,
        CCP_MODE_VFREQ  = 4'h7,
        CCP_MODE_EXT    = 4'hF
    } ccp_mode_t;

    typedef struct packed {
        logic       auto_restart_enable;
        logic       shutdown_gate_sync;
        logic       rsv13;
        logic       software_shutdown_force;
        logic [3:0] rsv11_8;
        logic [7:0] shutdown_source_enable;
    } ccp_sdc_t;

    typedef struct packed {
        logic fault_input_b;
        logic fault_input_a;
        logic logic_cell_out;
        logic comparator_three_out;
        logic comparator_two_out;
        logic comparator_one_out;
    } ccp_sd_src_t;

endpackage

// ---- ccp_chk_checker.sv ----
/* checker for ccp_oc: bus handshake, register bits, shutdown gating, modes.
   assumes whole-word writes to control and shutdown control from the bench. */
`timescale 1ns/1ps
`include "ccp_cfg.svh"
module ccp_chk (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic [5:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic [3:0]           avs_byteenable,
    input wire logic [31:0]          avs_readdata,
    input wire logic                 avs_waitrequest,
    input wire ccp_pkg::ccp_sd_src_t sd_src,
    input wire logic                 ext_input,
    input wire logic                 compare_out,
    input wire logic                 irq
);
    logic [15:0] ctl_q;
    logic [15:0] sdc_q;
    logic [2:0]  quiet_q;
    logic        wr_ok;
    logic        hw_req;
    assign wr_ok  = avs_write && !avs_waitrequest;
    assign hw_req = |({sdc_q[7:5], sdc_q[2:0]} & sd_src);
    //////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) ctl_q <= 16'h0000;
        else if (wr_ok && avs_address == `CCP_OFS_CTL) ctl_q <= avs_writedata[15:0];
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) sdc_q <= 16'h0000;
        else if (wr_ok && avs_address == `CCP_OFS_SDC) sdc_q <= avs_writedata[15:0];
    end
    // settle time after any write, so old waveform latency is not judged
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) quiet_q <= 3'd0;
        else if (wr_ok) quiet_q <= 3'd0;
        else if (quiet_q != 3'd7) quiet_q <= quiet_q + 3'd1;
    end
    //////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        s_taken ##1 !avs_waitrequest;
    endsequence
    AST_WAIT_ANSWER: assert property (s_taken |=> !avs_waitrequest) else $error("no answer");
    AST_WAIT_ONE: assert property (s_answer |=> avs_waitrequest) else $error("wait too short");
    AST_SDC_RSV: assert property (avs_read && !avs_waitrequest
        && avs_address == `CCP_OFS_SDC
        |-> (avs_readdata & 32'hFFFF_2F00) == 32'h0000_0000) else $error("reserved bit set");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 6'h23
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped read nonzero");
    AST_SHUT_NOW: assert property (hw_req && !sdc_q[14]
        |=> !compare_out) else $error("source did not shut down");
    AST_SW_FORCE: assert property ($rose(sdc_q[12]) && !sdc_q[14]
        |=> !compare_out [*2]) else $error("software force ignored");
    AST_WIDE_ONLY: assert property (ctl_q[5] && ctl_q[3:0] > 4'h3 && quiet_q == 3'd7
        |-> !compare_out) else $error("wide dual mode drives output");
    AST_HIGH_HOLDS: assert property (ctl_q[15] && ctl_q[3:0] == 4'h1 && quiet_q == 3'd7
        && compare_out && !hw_req && !sdc_q[12] |=> compare_out) else $error("high mode fell");
endmodule
bind ccp_oc ccp_chk u_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sd_src(sd_src), .ext_input(ext_input),
    .compare_out(compare_out), .irq(irq));

// ---- ccp_src_model.sv ----
/* fault pins, logic cell and comparators beside the compare stage.
   assumes the bench sets the wanted levels; they change after a clock edge. */
`timescale 1ns/1ps
module ccp_src_model (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic [5:0]      level_req,
    input  wire logic            ext_req,
    output ccp_pkg::ccp_sd_src_t sd_src,
    output logic                 ext_input
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sd_src    <= '0;
            ext_input <= 1'b0;
        end else begin
            sd_src    <= level_req;
            ext_input <= ext_req;
        end
    end
endmodule

// ---- test_ccp_oc.sv ----
/* self-checking bench for ccp_oc: registers, modes, interrupt, shutdown.
   assumes ccp_src_model drives the shutdown sources and external input. */
`timescale 1ns/1ps
`include "ccp_cfg.svh"
module test_ccp_oc;
    logic                 clk;
    logic                 rst_b;
    logic [5:0]           avs_address;
    logic                 avs_read;
    logic                 avs_write;
    logic [31:0]          avs_writedata;
    logic [3:0]           avs_byteenable;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic [5:0]           level_req;
    logic                 ext_req;
    logic                 ext_input;
    logic                 compare_out;
    logic                 irq;
    ccp_pkg::ccp_sd_src_t sd_src;
    logic [31:0]          q;
    int                   fails;
    int                   check_count;
    ccp_src_model u_src (.clk(clk), .rst_b(rst_b), .level_req(level_req), .ext_req(ext_req),
        .sd_src(sd_src), .ext_input(ext_input));
    ccp_oc dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sd_src(sd_src),
        .ext_input(ext_input), .compare_out(compare_out), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one access; read data land in q
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        if (n >= 40) begin
            fails++;
            summarize();
        end
    endtask
    task automatic count_high(output int ones);
        ones = 0;
        repeat (40) begin
            @(posedge clk);
            // an unknown level is pushed far off any expected count
            if (compare_out !== 1'b0 && compare_out !== 1'b1) begin
                ones += 1000;
            end else begin
                ones += int'(compare_out);
            end
        end
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        bus(0, `CCP_OFS_SDC, 0);
        cmp("sdc reset", 32'h0000_0000, q);
        bus(1, `CCP_OFS_SDC, 32'hFFFF_FFFF);
        bus(0, `CCP_OFS_SDC, 0);
        cmp("sdc bits", 32'h0000_D0FF, q);
        bus(1, `CCP_OFS_SDC, 0);
        bus(1, `CCP_OFS_EVT, 1);
        bus(0, 6'h24, 0);
        cmp("unmapped", 32'h0000_0000, q);
        avs_byteenable <= 4'h1;
        bus(1, `CCP_OFS_PER, 32'hFFFF_FF13);
        avs_byteenable <= 4'hF;
        bus(0, `CCP_OFS_PER, 0);
        cmp("byte lane", 32'h0000_0013, q);
    endtask
    // ctl word, compare a, compare b; period 19 gives a 20-cycle frame, 38 cycles in center mode
    task automatic t_modes;
        logic [31:0] tab [11] = '{32'h8001_050A, 32'h8002_050A, 32'h8003_050A,
            32'h8004_050A, 32'h8005_050A, 32'h8006_0014, 32'h8007_0400, 32'h800F_050A,
            32'h8022_050A, 32'h8021_050A, 32'h8024_050A};
        int exp1 [11] = '{40, 0, 20, 10, 10, 40, 20, 40, 0, 40, 0};
        int ones;
        ext_req <= 1'b1;
        bus(1, `CCP_OFS_PER, 19);
        for (int i = 0; i < 11; i++) begin
            // a timer left above the shorter top would run on to rollover
            if (i == 6) begin
                bus(1, `CCP_OFS_CTL, 0);
            end
            bus(1, `CCP_OFS_CMPA, tab[i][15:8]);
            bus(1, `CCP_OFS_CMPB, tab[i][7:0]);
            bus(1, `CCP_OFS_CTL, tab[i][31:16]);
            repeat (60) @(posedge clk);
            count_high(ones);
            cmp("high cycles", exp1[i], ones);
        end
        ext_req <= 1'b0;
    endtask
    task automatic t_irq;
        bus(1, `CCP_OFS_CTL, 32'h8003);
        repeat (25) @(posedge clk);
        bus(1, `CCP_OFS_CTL, 0);
        repeat (3) @(posedge clk);
        cmp("irq masked", 0, irq);
        bus(1, `CCP_OFS_MASK, 1);
        repeat (3) @(posedge clk);
        cmp("irq", 1, irq);
        bus(0, `CCP_OFS_STAT, 0);
        cmp("match status", 1, q[0]);
        repeat (3) @(posedge clk);
        cmp("irq cleared", 0, irq);
        bus(0, `CCP_OFS_STAT, 0);
        cmp("status cleared", 0, q[0]);
        bus(1, `CCP_OFS_MASK, 0);
    endtask
    task automatic t_shut;
        int bitpos [6] = '{0, 1, 2, 5, 6, 7};
        int ones;
        bus(1, `CCP_OFS_CMPA, 5);
        bus(1, `CCP_OFS_CMPB, 10);
        bus(1, `CCP_OFS_CTL, 32'h8005);
        for (int i = 0; i < 6; i++) begin
            level_req <= 6'd1 << i;
            repeat (5) @(posedge clk);
            bus(0, `CCP_OFS_EVT, 0);
            cmp("flag disabled src", 0, q[0]);
            bus(1, `CCP_OFS_SDC, 32'd1 << bitpos[i]);
            bus(0, `CCP_OFS_EVT, 0);
            cmp("flag", 1, q[0]);
            level_req <= 6'd0;
            count_high(ones);
            cmp("held low", 0, ones);
            bus(1, `CCP_OFS_EVT, 1);
            repeat (40) @(posedge clk);
            count_high(ones);
            cmp("resumed", 10, ones);
            bus(1, `CCP_OFS_SDC, 0);
        end
        bus(1, `CCP_OFS_SDC, 32'h9000);
        bus(0, `CCP_OFS_EVT, 0);
        cmp("forced", 1, q[0]);
        bus(1, `CCP_OFS_SDC, 32'h8000);
        repeat (45) @(posedge clk);
        count_high(ones);
        cmp("restarted", 10, ones);
        // stopped timer: a gated request must stay pending, not set the flag
        bus(1, `CCP_OFS_CTL, 0);
        bus(1, `CCP_OFS_SDC, 32'h5000);
        repeat (25) @(posedge clk);
        bus(0, `CCP_OFS_EVT, 0);
        cmp("gate pending", 32'h0000_0002, q);
        bus(1, `CCP_OFS_CTL, 32'h8005);
        repeat (25) @(posedge clk);
        bus(0, `CCP_OFS_EVT, 0);
        cmp("gated", 1, q[0]);
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        level_req = 6'h00;
        ext_req = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_modes();
        t_irq();
        t_shut();
        summarize();
    end
endmodule
